// [mape_motion_events.sv]
// activity/inactivity and pedometer event logic with its registers
// Behaviour
// - activity function runs only with sleep enable
// - slope is sample difference divided by two
// - slope magnitude compared to 6-bit threshold
// - inactivity overrides rate with 12.5 Hz
// - inactivity time is field times 512 samples
// - inactivity raises no interrupt at all
// - one sample above threshold restores rate
// - wake interrupt delayed by 2-bit field
// - wake held one sample, routed to pin A
// - pedometer runs when enabled, magnitude readable
// - step interrupt, optional delta-time window
// - debounce steps before first step interrupt
// - debounce restarts after idle debounce time
// - adaptive threshold never below programmed floor
// - 16-bit step count in two bytes
// - count kept, cleared only by clear bit
// - overflow event routed to pin B
// - unlatched pin B interrupts are short pulses
// - latched request held until status read
// - latched but unrouted pulses status bit
// - step scale 2 g default, 4 g selectable
`timescale 1ns/10ps
module mape_motion_events
    import mape_pkg::*;
#(
    parameter int BASE_CYC  = BASE_TICK_CYC,
    parameter int PULSE_CYC = PIN_PULSE_CYC
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // register access
    input  wire mape_reg_req_t reg_req,
    output logic [7:0]         reg_rdata,
    // acceleration samples
    input  wire logic          sample_valid,
    input  wire mape_sample_t  sample,
    // pins and rate
    output logic               interrupt_pin_a,
    output logic               interrupt_pin_b,
    output logic [3:0]         output_sample_rate,
    output logic               inactive_state_flag
);
    localparam int BW = $clog2(BASE_CYC);

    // ---- register file
    logic [7:0] rate_q, rate_d;     // rate and scale control
    logic [7:0] latch_q, latch_d;   // latch control
    logic [7:0] pina_q, pina_d;     // pin A routing
    logic [7:0] pinb_q, pinb_d;     // pin B routing
    logic [7:0] fifo_q, fifo_d;     // fifo and overflow routing
    logic [7:0] deb_q, deb_d;       // step debounce
    logic [7:0] wths_q, wths_d;     // wake threshold
    logic [7:0] wdur_q, wdur_d;     // wake and sleep duration
    logic [6:0] mint_q, mint_d;     // step floor and scale
    logic [7:0] dlt_q, dlt_d;       // delta-time window
    logic [7:0] func_q, func_d;     // embedded enables
    logic [7:0] rdat_q, rdat_d;     // read data
    logic       wr_any, clr_wr, stat_rd;
    logic       step_stat, ovf_stat, step_pin, ovf_pin;

    // ---- activity state
    mape_act_t    st_q, st_d;       // active or inactive
    logic [12:0]  sc_q, sc_d;       // quiet sample count
    mape_sample_t prev_q, prev_d;   // previous sample
    logic         wake_q, wake_d;   // wake interrupt level
    logic         wp_q, wp_d;       // wake pending
    logic [1:0]   wdl_q, wdl_d;     // wake delay left
    logic         over;             // any axis above threshold
    logic [15:0]  thr16;
    logic [13:0]  sleep_lim;

    // ---- pedometer state
    logic [BW-1:0] bc_q, bc_d;      // base tick prescaler
    logic [8:0]    t25c_q, t25c_d;  // 25 Hz divider
    logic [7:0]    mag_q, mag_d;    // acceleration magnitude
    logic [7:0]    sth_q, sth_d;    // adaptive step threshold
    logic          abv_q, abv_d;    // magnitude above threshold
    logic [14:0]   gap_q, gap_d;    // ticks since last step
    logic [2:0]    dbc_q, dbc_d;    // consecutive steps
    logic [15:0]   cnt_q, cnt_d;    // step count
    logic [21:0]   win_q, win_d;    // delta window ticks
    logic          ws_q, ws_d;      // step seen in window
    logic          tick, t25, step_raw, step_ok, step_evt, ovf_evt;
    logic [7:0]    mag_n, floor8;
    logic [17:0]   msum;
    logic          ped_en;

    // absolute slope of one axis
    function automatic logic [15:0] slope_mag(input logic [15:0] cur, input logic [15:0] prv);
        logic signed [16:0] d;
        logic signed [15:0] s;
        d = $signed({cur[15], cur}) - $signed({prv[15], prv});
        s = d[16:1];
        slope_mag = s[15] ? 16'(-s) : 16'(s);
    endfunction

    // absolute value of one sample axis
    function automatic logic [17:0] abs18(input logic [15:0] v);
        abs18 = v[15] ? 18'(-$signed(v)) : 18'(v);
    endfunction

    assign wr_any  = reg_req.wr;
    assign stat_rd = reg_req.rd && reg_req.addr == ADDR_FSTAT;
    assign clr_wr  = wr_any && reg_req.addr == ADDR_MINTHS && reg_req.wdata[CLR_BIT];
    assign ped_en  = func_q[PED_EN_BIT];

    // register writes and read mux
    always_comb begin
        rate_d  = rate_q;
        latch_d = latch_q;
        pina_d  = pina_q;
        pinb_d  = pinb_q;
        fifo_d  = fifo_q;
        deb_d   = deb_q;
        wths_d  = wths_q;
        wdur_d  = wdur_q;
        mint_d  = mint_q;
        dlt_d   = dlt_q;
        func_d  = func_q;
        rdat_d  = rdat_q;
        if (wr_any) begin
            case (reg_req.addr)
                ADDR_RATE:   rate_d  = reg_req.wdata;
                ADDR_LATCH:  latch_d = reg_req.wdata;
                ADDR_PINA:   pina_d  = reg_req.wdata;
                ADDR_PINB:   pinb_d  = reg_req.wdata;
                ADDR_FIFO:   fifo_d  = reg_req.wdata;
                ADDR_DEB:    deb_d   = reg_req.wdata;
                ADDR_WTHS:   wths_d  = reg_req.wdata;
                ADDR_WDUR:   wdur_d  = reg_req.wdata;
                ADDR_MINTHS: mint_d  = reg_req.wdata[6:0];
                ADDR_DELTA:  dlt_d   = reg_req.wdata;
                ADDR_FUNC:   func_d  = reg_req.wdata;
                default:     rdat_d  = rdat_q;
            endcase
        end
        // read data taken on the read strobe
        if (reg_req.rd) begin
            case (reg_req.addr)
                ADDR_MAG:    rdat_d = ped_en ? mag_q : 8'h00;
                ADDR_RATE:   rdat_d = rate_q;
                ADDR_LATCH:  rdat_d = latch_q;
                ADDR_PINA:   rdat_d = pina_q;
                ADDR_PINB:   rdat_d = pinb_q;
                ADDR_FIFO:   rdat_d = fifo_q;
                ADDR_DEB:    rdat_d = deb_q;
                ADDR_WTHS:   rdat_d = wths_q;
                ADDR_WDUR:   rdat_d = wdur_q;
                ADDR_WSRC:   rdat_d = {3'h0, st_q == ST_INACT, wake_q, 3'h0};
                ADDR_CNTL:   rdat_d = cnt_q[7:0];
                ADDR_CNTH:   rdat_d = cnt_q[15:8];
                ADDR_MINTHS: rdat_d = {1'b0, mint_q};
                ADDR_FSTAT:  rdat_d = {6'h00, ovf_stat, step_stat};
                ADDR_DELTA:  rdat_d = dlt_q;
                ADDR_FUNC:   rdat_d = func_q;
                default:     rdat_d = 8'h00;
            endcase
        end
    end

    // register file flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_q  <= ZERO_RST;
            latch_q <= ZERO_RST;
            pina_q  <= ZERO_RST;
            pinb_q  <= ZERO_RST;
            fifo_q  <= ZERO_RST;
            deb_q   <= DEB_RST;
            wths_q  <= ZERO_RST;
            wdur_q  <= ZERO_RST;
            mint_q  <= 7'h00;
            dlt_q   <= ZERO_RST;
            func_q  <= ZERO_RST;
            rdat_q  <= ZERO_RST;
        end else begin
            rate_q  <= rate_d;
            latch_q <= latch_d;
            pina_q  <= pina_d;
            pinb_q  <= pinb_d;
            fifo_q  <= fifo_d;
            deb_q   <= deb_d;
            wths_q  <= wths_d;
            wdur_q  <= wdur_d;
            mint_q  <= mint_d;
            dlt_q   <= dlt_d;
            func_q  <= func_d;
            rdat_q  <= rdat_d;
        end
    end

    // threshold, one LSB is 1/64 of full scale
    assign thr16     = {1'b0, wths_q[5:0], 9'h000};
    assign sleep_lim = 14'(wdur_q[3:0]) * 14'(SLEEP_LSB_SMP);
    assign over = (slope_mag(sample.x, prev_q.x) > thr16)
                | (slope_mag(sample.y, prev_q.y) > thr16)
                | (slope_mag(sample.z, prev_q.z) > thr16);

    // activity, inactivity and wake timing per sample
    always_comb begin
        st_d   = st_q;
        sc_d   = sc_q;
        prev_d = prev_q;
        wake_d = wake_q;
        wp_d   = wp_q;
        wdl_d  = wdl_q;
        if (sample_valid) begin
            prev_d = sample;
            wake_d = 1'b0;
            if (wp_q) begin
                // delayed wake counts down one per sample
                if (wdl_q == 2'h1) begin
                    wake_d = 1'b1;
                    wp_d   = 1'b0;
                end else begin
                    wdl_d = wdl_q - 2'h1;
                end
            end
            if (!wths_q[SLEEP_ON_BIT]) begin
                st_d = ST_ACT;
                sc_d = 13'h0000;
                wp_d = 1'b0;
            end else if (over) begin
                st_d = ST_ACT;
                sc_d = 13'h0000;
                if (wdur_q[6:5] == 2'h0) begin
                    wake_d = 1'b1;
                end else begin
                    wp_d  = 1'b1;
                    wdl_d = wdur_q[6:5];
                end
            end else if (st_q == ST_ACT) begin
                // quiet sample; enter inactivity silently
                if (14'(sc_q) + 14'h0001 >= sleep_lim) begin
                    st_d = ST_INACT;
                    sc_d = 13'h0000;
                end else begin
                    sc_d = sc_q + 13'h0001;
                end
            end
        end
    end

    // activity flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= ST_ACT;
            sc_q   <= 13'h0000;
            prev_q <= '0;
            wake_q <= 1'b0;
            wp_q   <= 1'b0;
            wdl_q  <= 2'h0;
        end else begin
            st_q   <= st_d;
            sc_q   <= sc_d;
            prev_q <= prev_d;
            wake_q <= wake_d;
            wp_q   <= wp_d;
            wdl_q  <= wdl_d;
        end
    end

    // fixed 25 Hz pedometer timebase
    assign tick   = bc_q == BW'(BASE_CYC - 1);
    assign t25    = tick && t25c_q == 9'(ODR25_TICKS - 1);
    assign msum   = abs18(prev_q.x) + abs18(prev_q.y) + abs18(prev_q.z);
    assign floor8 = {mint_q[5:0], 2'h0};
    // magnitude at 2 g or 4 g step scale
    always_comb begin
        if (mint_q[SCALE4_BIT]) begin
            mag_n = (msum[17] != 1'b0) ? 8'hff : msum[16:9];
        end else begin
            mag_n = (msum[17:16] != 2'h0) ? 8'hff : msum[15:8];
        end
    end
    assign step_raw = t25 && ped_en && mag_n > sth_q && !abv_q;
    assign step_ok  = step_raw && 4'(dbc_q) + 4'h1 >= 4'(deb_q[7:5]);
    assign ovf_evt  = step_ok && !clr_wr && cnt_q == 16'hffff;

    // step detection, debounce, count and window
    always_comb begin
        bc_d     = tick ? '0 : bc_q + BW'(1);
        t25c_d   = t25 ? 9'h000 : (tick ? t25c_q + 9'h001 : t25c_q);
        mag_d    = mag_q;
        sth_d    = sth_q;
        abv_d    = abv_q;
        gap_d    = gap_q;
        dbc_d    = dbc_q;
        win_d    = win_q;
        ws_d     = ws_q;
        step_evt = 1'b0;
        cnt_d    = clr_wr ? 16'h0000 : cnt_q;
        if (step_ok) begin
            cnt_d = cnt_d + 16'h0001;
        end
        if (!ped_en) begin
            sth_d = floor8;
            abv_d = 1'b0;
            dbc_d = 3'h0;
            win_d = 22'h00_0000;
            ws_d  = 1'b0;
        end else begin
            if (t25) begin
                mag_d = mag_n;
                abv_d = mag_n > sth_q;
                if (step_raw) begin
                    sth_d = (mag_n > floor8) ? mag_n : floor8;
                end else if (sth_q > floor8) begin
                    sth_d = sth_q - 8'h01;
                end else begin
                    sth_d = floor8;
                end
            end
            if (step_raw) begin
                gap_d = 15'h0000;
                dbc_d = (dbc_q == 3'h7) ? dbc_q : dbc_q + 3'h1;
            end else begin
                if (tick && gap_q != 15'h7fff) begin
                    gap_d = gap_q + 15'h0001;
                end
                if (gap_q >= 15'(deb_q[4:0]) * 15'(DEB_LSB_TICKS)) begin
                    dbc_d = 3'h0;
                end
            end
            if (dlt_q == 8'h00) begin
                step_evt = step_ok;
            end else if (tick && 22'(win_q) + 22'h00_0001
                         >= 22'(dlt_q) * 22'(DLT_LSB_TICKS)) begin
                step_evt = ws_q | step_ok;
                win_d    = 22'h00_0000;
                ws_d     = 1'b0;
            end else begin
                win_d = tick ? win_q + 22'h00_0001 : win_q;
                ws_d  = ws_q | step_ok;
            end
        end
    end

    // pedometer flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bc_q   <= '0;
            t25c_q <= 9'h000;
            mag_q  <= 8'h00;
            sth_q  <= 8'h00;
            abv_q  <= 1'b0;
            gap_q  <= 15'h0000;
            dbc_q  <= 3'h0;
            cnt_q  <= 16'h0000;
            win_q  <= 22'h00_0000;
            ws_q   <= 1'b0;
        end else begin
            bc_q   <= bc_d;
            t25c_q <= t25c_d;
            mag_q  <= mag_d;
            sth_q  <= sth_d;
            abv_q  <= abv_d;
            gap_q  <= gap_d;
            dbc_q  <= dbc_d;
            cnt_q  <= cnt_d;
            win_q  <= win_d;
            ws_q   <= ws_d;
        end
    end

    // step interrupt shaping
    mape_evt_route #(.PULSE_CYC(PULSE_CYC), .HOLD_TICKS(ODR25_TICKS)) u_step (
        .clk      (clk),
        .rst_n    (rst_n),
        .evt      (step_evt),
        .routed   (pinb_q[STEP_PIN_BIT]),
        .latch_en (latch_q[LIR_BIT]),
        .clr_rd   (stat_rd),
        .tick     (tick),
        .pin      (step_pin),
        .status   (step_stat)
    );

    // overflow interrupt shaping
    mape_evt_route #(.PULSE_CYC(PULSE_CYC), .HOLD_TICKS(ODR25_TICKS)) u_ovf (
        .clk      (clk),
        .rst_n    (rst_n),
        .evt      (ovf_evt),
        .routed   (fifo_q[OVF_PIN_BIT]),
        .latch_en (latch_q[LIR_BIT]),
        .clr_rd   (stat_rd),
        .tick     (tick),
        .pin      (ovf_pin),
        .status   (ovf_stat)
    );

    // outputs; sleep state never reaches a pin
    assign interrupt_pin_a     = wake_q & pina_q[WAKE_PIN_BIT];
    assign interrupt_pin_b     = step_pin | ovf_pin;
    assign output_sample_rate  = (st_q == ST_INACT) ? RATE_12HZ5 : rate_q[7:4];
    assign inactive_state_flag = st_q == ST_INACT;
    assign reg_rdata           = rdat_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_over_smp;
        sample_valid && wths_q[SLEEP_ON_BIT] && over;
    endsequence

    property p_sleep_off;
        !wths_q[SLEEP_ON_BIT] && sample_valid |=> st_q == ST_ACT;
    endproperty
    a_sleep_off: assert property (p_sleep_off) else $error("inactive without enable");

    property p_wake_back;
        s_over_smp |=> st_q == ST_ACT && output_sample_rate == rate_q[7:4];
    endproperty
    a_wake_back: assert property (p_wake_back) else $error("rate not restored");

    property p_rate;
        st_q == ST_INACT |-> output_sample_rate == RATE_12HZ5;
    endproperty
    a_rate: assert property (p_rate) else $error("sleep rate wrong");

    property p_no_sleep_irq;
        $rose(st_q == ST_INACT) |-> !$rose(interrupt_pin_a);
    endproperty
    a_no_sleep_irq: assert property (p_no_sleep_irq) else $error("irq on sleep");

    property p_wake_now;
        s_over_smp and wdur_q[6:5] == 2'h0 |=> wake_q;
    endproperty
    a_wake_now: assert property (p_wake_now) else $error("wake not immediate");

    property p_wake_len;
        wake_q && sample_valid && !over && !wp_q |=> !wake_q;
    endproperty
    a_wake_len: assert property (p_wake_len) else $error("wake too long");

    property p_ped_off;
        !ped_en |-> !step_raw && cnt_d == (clr_wr ? 16'h0000 : cnt_q);
    endproperty
    a_ped_off: assert property (p_ped_off) else $error("step while disabled");

    property p_cnt_hold;
        !clr_wr && !step_ok |=> cnt_q == $past(cnt_q);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("count changed");

    property p_ovf;
        ovf_evt |=> cnt_q == 16'h0000;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow wrap wrong");

    property p_floor;
        t25 && ped_en && !wr_any |=> sth_q >= floor8;
    endproperty
    a_floor: assert property (p_floor) else $error("threshold below floor");
endmodule

// [mape_pkg.sv]
// shared constants, types and carriers for the motion event block
package mape_pkg;
    // register offsets
    localparam logic [7:0] ADDR_MAG    = 8'h0c;
    localparam logic [7:0] ADDR_RATE   = 8'h20;
    localparam logic [7:0] ADDR_LATCH  = 8'h22;
    localparam logic [7:0] ADDR_PINA   = 8'h23;
    localparam logic [7:0] ADDR_PINB   = 8'h24;
    localparam logic [7:0] ADDR_FIFO   = 8'h25;
    localparam logic [7:0] ADDR_DEB    = 8'h2b;
    localparam logic [7:0] ADDR_WTHS   = 8'h33;
    localparam logic [7:0] ADDR_WDUR   = 8'h34;
    localparam logic [7:0] ADDR_WSRC   = 8'h38;
    localparam logic [7:0] ADDR_CNTL   = 8'h3a;
    localparam logic [7:0] ADDR_CNTH   = 8'h3b;
    localparam logic [7:0] ADDR_MINTHS = 8'h3c;
    localparam logic [7:0] ADDR_FSTAT  = 8'h3d;
    localparam logic [7:0] ADDR_DELTA  = 8'h3e;
    localparam logic [7:0] ADDR_FUNC   = 8'h3f;
    // field positions
    localparam int SLEEP_ON_BIT  = 6;
    localparam int LIR_BIT       = 0;
    localparam int WAKE_PIN_BIT  = 5;
    localparam int STEP_PIN_BIT  = 2;
    localparam int OVF_PIN_BIT   = 4;
    localparam int CLR_BIT       = 7;
    localparam int SCALE4_BIT    = 6;
    localparam int PED_EN_BIT    = 0;
    localparam int WSRC_SLEEP    = 4;
    localparam int WSRC_WAKE     = 3;
    // reset values
    localparam logic [7:0] DEB_RST  = 8'hed;
    localparam logic [7:0] ZERO_RST = 8'h00;
    // internal sleep rate code
    localparam logic [3:0] RATE_12HZ5 = 4'h1;
    // timing
    localparam int CLK_PS        = 4000;
    localparam int BASE_TICK_PS  = 100000000;
    localparam int BASE_TICK_CYC = BASE_TICK_PS / CLK_PS;
    localparam int PIN_PULSE_PS  = 60000000;
    localparam int PIN_PULSE_CYC = PIN_PULSE_PS / CLK_PS;
    localparam int ODR25_TICKS   = 400;
    localparam int DEB_LSB_TICKS = 800;
    localparam int DLT_LSB_TICKS = 16384;
    localparam int SLEEP_LSB_SMP = 512;
    // activity states
    typedef enum logic [0:0] {
        ST_ACT   = 1'b0,
        ST_INACT = 1'b1
    } mape_act_t;
    // register access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mape_reg_req_t;
    // one three-axis sample, signed
    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [15:0] z;
    } mape_sample_t;
endpackage

// [mape_evt_route.sv]
// pin and status shaping of one pedometer event
`timescale 1ns/10ps
module mape_evt_route
    import mape_pkg::*;
#(
    parameter int PULSE_CYC  = PIN_PULSE_CYC,
    parameter int HOLD_TICKS = ODR25_TICKS
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // event and configuration
    input  wire logic evt,
    input  wire logic routed,
    input  wire logic latch_en,
    input  wire logic clr_rd,
    input  wire logic tick,
    // shaped outputs
    output logic      pin,
    output logic      status
);
    localparam int PW = $clog2(PULSE_CYC + 1);
    localparam int SW = $clog2(HOLD_TICKS + 1);
    logic          held_q, held_d;   // latched request
    logic [PW-1:0] pcnt_q, pcnt_d;   // pin pulse length
    logic [SW-1:0] scnt_q, scnt_d;   // status pulse length
    logic          lmode;            // latched and routed

    // next state of the three shapers
    always_comb begin
        lmode  = latch_en & routed;
        held_d = held_q;
        pcnt_d = pcnt_q;
        scnt_d = scnt_q;
        // a status read clears, a new event wins
        if (clr_rd) begin
            held_d = 1'b0;
        end
        if (evt && lmode) begin
            held_d = 1'b1;
        end
        // short pin pulse when not latched
        if (pcnt_q != '0) begin
            pcnt_d = pcnt_q - PW'(1);
        end
        if (evt && routed && !latch_en) begin
            pcnt_d = PW'(PULSE_CYC);
        end
        // status bit pulses one 25 Hz period
        if (tick && scnt_q != '0) begin
            scnt_d = scnt_q - SW'(1);
        end
        if (evt && !lmode) begin
            scnt_d = SW'(HOLD_TICKS);
        end
    end

    // registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held_q <= 1'b0;
            pcnt_q <= '0;
            scnt_q <= '0;
        end else begin
            held_q <= held_d;
            pcnt_q <= pcnt_d;
            scnt_q <= scnt_d;
        end
    end

    assign pin    = held_q | (pcnt_q != '0);
    assign status = held_q | (scnt_q != '0);
endmodule

// [mape_host_model.sv]
// host model driving the register port of the motion event block
`timescale 1ns/10ps
module mape_host_model
    import mape_pkg::*;
(
    // clock
    input  wire logic       clk,
    // register port
    output mape_reg_req_t   reg_req,
    input  wire logic [7:0] reg_rdata
);
    // idle port from time zero
    initial reg_req = '0;
    // one write strobe over one rising edge, address scrambled after
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // one read strobe, data registered one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
        d = reg_rdata;
    endtask
endmodule

// [mape_motion_events_tb_top.sv]
// self-checking bench for the motion event block
`timescale 1ns/10ps
module mape_motion_events_tb_top
    import mape_pkg::*;
;
    logic          clk;
    logic          rst_n;
    mape_reg_req_t reg_req;
    logic [7:0]    reg_rdata;
    logic          sample_valid;
    mape_sample_t  sample;
    logic          pin_a;
    logic          pin_b;
    logic [3:0]    rate;
    logic          inact;
    logic [15:0]   cur_x;
    logic [7:0]    rv;
    int            failures;
    int            checked;
    // 250 MHz clock
    always #2 clk = ~clk;
    mape_host_model host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
    mape_motion_events #(.BASE_CYC(4), .PULSE_CYC(3)) dut (
        .clk(clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .sample_valid(sample_valid), .sample(sample), .interrupt_pin_a(pin_a),
        .interrupt_pin_b(pin_b), .output_sample_rate(rate), .inactive_state_flag(inact));
    // compare and count
    task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // one sample pulse on the x axis
    task automatic send(input logic [15:0] x);
        @(negedge clk);
        sample_valid = 1'b1;
        sample = '{x: x, y: 16'h0000, z: 16'h0000};
        cur_x = x;
        @(negedge clk);
        sample_valid = 1'b0;
    endtask
    // reset values, unmapped read, magnitude while disabled
    task automatic t_regs();
        host.rd(ADDR_DEB, rv); check("deb", rv, DEB_RST);
        host.rd(8'h01, rv); check("unmapped", rv, 8'h00);
        host.rd(ADDR_MAG, rv); check("mag", rv, 8'h00);
        host.wr(ADDR_FIFO, 8'h10);
        host.rd(ADDR_FIFO, rv); check("fifo", rv, 8'h10);
        host.wr(ADDR_MINTHS, 8'h80);
        host.rd(ADDR_CNTL, rv); check("cnt", rv, 8'h00);
        $display("test regs done");
    endtask
    // inactivity after 512 quiet samples, then delayed wake
    task automatic t_wake(input logic [1:0] dly, input logic [15:0] dx);
        host.wr(ADDR_WDUR, {1'b0, dly, 5'h01});
        // an active sample restarts the quiet count from zero
        send(cur_x + dx);
        repeat (511) send(cur_x);
        check("early", inact, 1'b0);
        send(cur_x);
        check("inact", inact, 1'b1);
        check("slow", rate, RATE_12HZ5);
        check("noirq", pin_a, 1'b0);
        host.rd(ADDR_RATE, rv); check("ctrl", rv, 8'h50);
        send(cur_x + 16'h0800);
        check("edge", inact, 1'b1);
        send(cur_x + dx);
        check("rate", rate, 4'h5);
        check("act", inact, 1'b0);
        repeat (dly) begin
            check("delay", pin_a, 1'b0);
            send(cur_x);
        end
        check("wake", pin_a, 1'b1);
        send(cur_x);
        check("wake_end", pin_a, 1'b0);
        $display("test wake done");
    endtask
    // no inactivity and no wake with sleep disabled
    task automatic t_sleep_off();
        host.wr(ADDR_WTHS, 8'h02);
        repeat (513) send(cur_x);
        check("off", inact, 1'b0);
        send(cur_x + 16'h1000);
        check("off_pin", pin_a, 1'b0);
        $display("test sleep off done");
    endtask
    // one unlatched step on pin B, count kept over disable
    task automatic t_step();
        int n;
        host.wr(ADDR_DEB, 8'h2d);
        host.wr(ADDR_PINB, 8'h04);
        host.wr(ADDR_FUNC, 8'h01);
        send(16'h4000);
        n = 0;
        // first 25 Hz event comes within 1600 clocks
        while (!pin_b && n < 2000) begin
            @(negedge clk);
            n++;
        end
        check("step_pin", pin_b, 1'b1);
        repeat (2) @(negedge clk);
        check("pulse_on", pin_b, 1'b1);
        @(negedge clk);
        check("pulse_off", pin_b, 1'b0);
        host.rd(ADDR_CNTL, rv); check("steps", rv, 8'h01);
        host.rd(ADDR_MAG, rv); check("mag_on", rv, 8'h40);
        host.rd(ADDR_FSTAT, rv); check("stat", rv, 8'h01);
        host.wr(ADDR_FUNC, 8'h00);
        host.rd(ADDR_CNTL, rv); check("kept", rv, 8'h01);
        host.wr(ADDR_MINTHS, 8'h80);
        host.rd(ADDR_CNTL, rv); check("cleared", rv, 8'h00);
        $display("test step done");
    endtask
    // verdict and end of run
    task automatic conclude();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // main sequence; rate code 5 is the active rate each wake test expects back
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        sample_valid = 1'b0;
        sample = '0;
        cur_x = 16'h0000;
        failures = 0;
        checked = 0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        t_regs();
        host.wr(ADDR_RATE, 8'h50);
        host.wr(ADDR_PINA, 8'h20);
        host.wr(ADDR_WTHS, 8'h42);
        t_wake(2'd0, 16'h0802);
        t_wake(2'd2, 16'hf7fe);
        t_sleep_off();
        t_step();
        conclude();
    end
    // watchdog, about eight times the three thousand two hundred clocks the tests need
    initial begin
        #100000;
        failures++;
        conclude();
    end
endmodule
